// ---- pkg/i2c_slave_pkg.sv ----
// constants shared by the i2c slave block: register map, field
// positions, reset values, state encoding and timing figures.
// assumes a 200 mhz pclk and a 32-bit apb register bus.
`default_nettype none

package i2c_slave_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_MODULE_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDRESS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SERIAL_DATA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TIMEOUT_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h1c;

  // module_control_reg fields
  localparam int MC_MODE_LSB = 5;
  localparam int MC_DEB_LSB = 2;
  localparam int MC_ENABLE = 1;
  localparam int MC_INCOMPLETE = 0;
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;

  // i2c_status_control fields
  localparam int SC_HTX = 4;
  localparam int SC_TX_ACK_CTRL = 3;
  localparam int SC_WAKE_EN = 1;

  // timeout_control_reg fields
  localparam int TC_ENABLE = 7;
  localparam int TC_FLAG = 6;

  // irq status / mask bits
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_BYTE = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_N = 3;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // timeout unit is 32 periods of the slow clock (about 32 kHz)
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TO_UNIT_NS = 976563;
  localparam int unsigned TO_UNIT_CYCLES = TO_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_RX_ACK = 3'h6,
    ST_TX = 3'h7,
    ST_TX_ACK = 3'h5
  } link_state_e;

endpackage

`default_nettype wire

// ---- src/pin_sync.sv ----
// two-flop synchroniser for pins that come from outside pclk.
// assumes nothing but a free running pclk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      pin_sync_out <= '1;
    end else begin
      meta_reg <= pin_in;
      pin_sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ---- src/i2c_slave_interface.sv ----
// i2c slave engine with apb register file, sticky interrupts and
// bus time-out. scl and sda are open-drain pins seen from outside
// pclk; they are synchronised before use.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_interface
  import i2c_slave_pkg::*;
#(
  parameter int unsigned TO_CYCLES = i2c_slave_pkg::TO_UNIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_slave_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq,
  output logic wake_req
);
  import i2c_slave_pkg::*;

  localparam int DIV_W = $clog2(TO_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TO_CYCLES - 1);

  typedef struct packed {
    link_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] data;
    logic [6:0] own_addr;
    logic [2:0] mode;
    logic [1:0] deb;
    logic en;
    logic icf;
    logic xfer_complete_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic htx;
    logic tx_ack_ctrl;
    logic rw_dir_flag;
    logic addr_match_wake_en;
    logic rx_ack_flag;
    logic to_en;
    logic to_flag;
    logic [5:0] to_sel;
    logic to_run;
    logic [DIV_W-1:0] to_div;
    logic [5:0] to_units;
    logic [IRQ_N-1:0] irq_st;
    logic [IRQ_N-1:0] irq_mask;
    logic irq_en;
    logic hold;
    logic sda_drv;
    logic scl_prev;
    logic sda_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic wake;
  } slave_s;

  slave_s r_reg;
  slave_s r_next;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic active;
  logic wr_acc;
  logic rd_data;
  logic wr_data;
  logic addr_hit;
  logic to_fire;
  logic [IRQ_N-1:0] ev;

  pin_sync #(.WIDTH(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({scl_in, sda_in}),
    .pin_sync_out(pins_s)
  );

  // link back to idle with the status flags at their power-on values
  function automatic slave_s drop_link(slave_s s);
    slave_s t;
    t = s;
    t.state = ST_IDLE;
    t.hold = 1'b0;
    t.sda_drv = 1'b0;
    t.to_run = 1'b0;
    t.xfer_complete_flag = 1'b1;
    t.addr_match_flag = 1'b0;
    t.bus_busy_flag = 1'b0;
    t.rw_dir_flag = 1'b0;
    t.rx_ack_flag = 1'b1;
    return t;
  endfunction

  function automatic logic [7:0] status_byte(slave_s s);
    return {s.xfer_complete_flag, s.addr_match_flag, s.bus_busy_flag, s.htx, s.tx_ack_ctrl, s.rw_dir_flag, s.addr_match_wake_en, s.rx_ack_flag};
  endfunction

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s && !r_reg.scl_prev;
  assign scl_fall = !scl_s && r_reg.scl_prev;
  assign start_det = scl_s && r_reg.scl_prev && !sda_s && r_reg.sda_prev;
  assign stop_det = scl_s && r_reg.scl_prev && sda_s && !r_reg.sda_prev;
  assign active = r_reg.en && (r_reg.mode == MODE_I2C_SLAVE);
  assign wr_acc = psel && penable && pwrite && r_reg.pready;
  assign rd_data = psel && penable && !pwrite && r_reg.pready &&
                   (paddr == OFS_SERIAL_DATA);
  assign wr_data = wr_acc && (paddr == OFS_SERIAL_DATA);
  assign addr_hit = r_reg.shift[7:1] == r_reg.own_addr;

  always_comb begin
    r_next = r_reg;
    ev = '0;
    to_fire = 1'b0;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.wake = 1'b0;
    r_next.scl_prev = scl_s;
    r_next.sda_prev = sda_s;

    // apb setup phase: prepare the answer for the access edge
    if (psel && !penable && !r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.prdata = '0;
      if (paddr == OFS_MODULE_CONTROL) begin
        r_next.prdata[7:0] = {r_reg.mode, 1'b0, r_reg.deb, r_reg.en,
                              r_reg.icf};
      end else if (paddr == OFS_STATUS_CONTROL) begin
        r_next.prdata[7:0] = status_byte(r_reg);
      end else if (paddr == OFS_OWN_ADDRESS) begin
        r_next.prdata[6:0] = r_reg.own_addr;
      end else if (paddr == OFS_SERIAL_DATA) begin
        r_next.prdata[7:0] = r_reg.data;
      end else if (paddr == OFS_TIMEOUT_CONTROL) begin
        r_next.prdata[7:0] = {r_reg.to_en, r_reg.to_flag, r_reg.to_sel};
      end else if (paddr == OFS_IRQ_STATUS) begin
        r_next.prdata[IRQ_N-1:0] = r_reg.irq_st;
      end else if (paddr == OFS_IRQ_MASK) begin
        r_next.prdata[IRQ_N-1:0] = r_reg.irq_mask;
      end else if (paddr == OFS_IRQ_ENABLE) begin
        r_next.prdata[0] = r_reg.irq_en;
      end else begin
        r_next.pslverr = 1'b1;
      end
    end

    // apb access phase writes; hardware events below win over them
    if (wr_acc) begin
      if (paddr == OFS_MODULE_CONTROL) begin
        r_next.mode = pwdata[MC_MODE_LSB+2:MC_MODE_LSB];
        r_next.deb = pwdata[MC_DEB_LSB+1:MC_DEB_LSB];
        r_next.en = pwdata[MC_ENABLE];
        r_next.icf = pwdata[MC_INCOMPLETE];
      end else if (paddr == OFS_STATUS_CONTROL) begin
        r_next.htx = pwdata[SC_HTX];
        r_next.tx_ack_ctrl = pwdata[SC_TX_ACK_CTRL];
        r_next.addr_match_wake_en = pwdata[SC_WAKE_EN];
      end else if (paddr == OFS_OWN_ADDRESS) begin
        r_next.own_addr = pwdata[6:0];
      end else if (paddr == OFS_SERIAL_DATA) begin
        r_next.data = pwdata[7:0];
      end else if (paddr == OFS_TIMEOUT_CONTROL) begin
        r_next.to_en = pwdata[TC_ENABLE];
        r_next.to_flag = pwdata[TC_FLAG];
        r_next.to_sel = pwdata[5:0];
      end else if (paddr == OFS_IRQ_STATUS) begin
        r_next.irq_st = r_reg.irq_st & ~pwdata[IRQ_N-1:0];
      end else if (paddr == OFS_IRQ_MASK) begin
        r_next.irq_mask = pwdata[IRQ_N-1:0];
      end else if (paddr == OFS_IRQ_ENABLE) begin
        r_next.irq_en = pwdata[0];
      end
    end

    if (!active) begin
      r_next = drop_link(r_next);
    end else if (start_det) begin
      r_next.bus_busy_flag = 1'b1;
      r_next.addr_match_flag = 1'b0;
      r_next.state = ST_ADDR;
      r_next.bitcnt = '0;
      r_next.hold = 1'b0;
      r_next.sda_drv = 1'b0;
    end else if (stop_det) begin
      r_next.bus_busy_flag = 1'b0;
      r_next.state = ST_IDLE;
      r_next.hold = 1'b0;
      r_next.sda_drv = 1'b0;
      r_next.to_run = 1'b0;
    end else begin
      case (r_reg.state)
        ST_ADDR: begin
          if (scl_rise) begin
            r_next.shift = {r_reg.shift[6:0], sda_s};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == BITS_PER_BYTE) begin
            if (addr_hit) begin
              r_next.addr_match_flag = 1'b1;
              r_next.rw_dir_flag = r_reg.shift[0];
              r_next.sda_drv = 1'b1;
              r_next.state = ST_ADDR_ACK;
              r_next.to_run = 1'b1;
              r_next.wake = r_reg.addr_match_wake_en;
              ev[IRQ_MATCH] = 1'b1;
            end else begin
              r_next.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            r_next.sda_drv = 1'b0;
            r_next.hold = 1'b1;
            r_next.bitcnt = '0;
            r_next.state = r_reg.rw_dir_flag ? ST_TX : ST_RX;
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            if (r_reg.bitcnt == '0) begin
              r_next.xfer_complete_flag = 1'b0;
            end
            r_next.shift = {r_reg.shift[6:0], sda_s};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == BITS_PER_BYTE) begin
            r_next.data = r_reg.shift;
            r_next.xfer_complete_flag = 1'b1;
            ev[IRQ_BYTE] = 1'b1;
            r_next.sda_drv = !r_reg.tx_ack_ctrl;
            r_next.state = ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            r_next.sda_drv = 1'b0;
            r_next.bitcnt = '0;
            r_next.state = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            r_next.xfer_complete_flag = 1'b0;
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
            if (r_reg.bitcnt == LAST_TX_BIT) begin
              r_next.sda_drv = 1'b0;
              r_next.xfer_complete_flag = 1'b1;
              ev[IRQ_BYTE] = 1'b1;
              r_next.state = ST_TX_ACK;
            end else begin
              r_next.shift = {r_reg.shift[6:0], 1'b0};
              r_next.sda_drv = !r_reg.shift[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            r_next.rx_ack_flag = sda_s;
          end else if (scl_fall) begin
            if (!r_reg.rx_ack_flag) begin
              r_next.state = ST_TX;
              r_next.bitcnt = '0;
              r_next.shift = r_reg.data;
              r_next.sda_drv = !r_reg.data[7];
            end else begin
              r_next.state = ST_IDLE;
              r_next.sda_drv = 1'b0;
            end
          end
        end
        default: begin
          r_next.sda_drv = 1'b0;
        end
      endcase

      // data write in transmit mode or dummy read in receive mode
      if (r_reg.hold && ((r_reg.htx && wr_data) ||
                         (!r_reg.htx && rd_data))) begin
        r_next.hold = 1'b0;
        if (r_reg.htx) begin
          r_next.shift = pwdata[7:0];
          r_next.sda_drv = !pwdata[7];
        end
      end

      // time-out: restarted by every scl fall, stopped by stop
      if (r_reg.to_run && r_reg.to_en && !scl_fall) begin
        if (r_reg.to_div == DIV_LAST) begin
          r_next.to_div = '0;
          if (r_reg.to_units == r_reg.to_sel) begin
            to_fire = 1'b1;
          end else begin
            r_next.to_units = r_reg.to_units + 6'h1;
          end
        end else begin
          r_next.to_div = r_reg.to_div + DIV_W'(1);
        end
      end else begin
        r_next.to_div = '0;
        r_next.to_units = '0;
      end
      if (to_fire) begin
        r_next = drop_link(r_next);
        r_next.htx = 1'b0;
        r_next.tx_ack_ctrl = 1'b0;
        r_next.addr_match_wake_en = 1'b0;
        r_next.to_en = 1'b0;
        r_next.to_flag = 1'b1;
        ev[IRQ_TIMEOUT] = 1'b1;
      end
    end

    r_next.irq_st = r_next.irq_st | ev;
    r_next.irq = r_next.irq_en && |(r_next.irq_st & r_next.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.mode <= MODE_RESET;
      r_reg.xfer_complete_flag <= 1'b1;
      r_reg.rx_ack_flag <= 1'b1;
      r_reg.scl_prev <= 1'b1;
      r_reg.sda_prev <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r_reg.hold;
  assign sda_oe = r_reg.sda_drv;
  assign irq = r_reg.irq;
  assign wake_req = r_reg.wake;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_addr_done;
    active && !start_det && !stop_det && r_reg.state == ST_ADDR &&
      scl_fall && r_reg.bitcnt == BITS_PER_BYTE && addr_hit;
  endsequence

  chk_start_busy: assert property (
    active && start_det |=> r_reg.bus_busy_flag && r_reg.state == ST_ADDR)
    else $error("start did not set busy");
  chk_stop_free: assert property (
    active && stop_det |=> !r_reg.bus_busy_flag && !sda_oe)
    else $error("stop did not free the bus");
  chk_match_ack: assert property (
    s_addr_done |=> r_reg.addr_match_flag && sda_oe && r_reg.irq_st[IRQ_MATCH])
    else $error("matched address not acknowledged");
  chk_dir_capture: assert property (
    s_addr_done |=> r_reg.rw_dir_flag == $past(r_reg.shift[0]))
    else $error("direction bit not captured");
  chk_rx_ack_level: assert property (
    r_reg.state == ST_RX && r_next.state == ST_RX_ACK && active
    |=> sda_oe == !$past(r_reg.tx_ack_ctrl))
    else $error("receive ack does not follow tx_ack_ctrl");
  chk_rx_ack_sample: assert property (
    active && !start_det && !stop_det && !to_fire &&
    r_reg.state == ST_TX_ACK && scl_rise |=> r_reg.rx_ack_flag == $past(sda_s))
    else $error("master ack not sampled");
  chk_tx_release: assert property (
    active && !start_det && !stop_det && !to_fire &&
    r_reg.state == ST_TX_ACK && scl_fall && r_reg.rx_ack_flag
    |=> !sda_oe && r_reg.state == ST_IDLE)
    else $error("sda not released after nack");
  chk_scl_hold: assert property (
    active && !start_det && !stop_det && !to_fire &&
    r_reg.state == ST_ADDR_ACK && scl_fall |=> scl_oe [*2])
    else $error("scl not held after match");
  chk_no_start: assert property (
    $rose(sda_oe) |-> !scl_s)
    else $error("slave drove sda low while scl high");
  // a time-out resets hcf one cycle after it fires, with no byte event
  chk_byte_flag: assert property (
    $rose(r_reg.xfer_complete_flag) && active && !$past(to_fire)
    |-> r_reg.irq_st[IRQ_BYTE])
    else $error("byte completion without interrupt status");
  // an event must survive a clear written in the same cycle
  chk_irq_level: assert property (
    r_next.irq_en && |(ev & r_next.irq_mask)
    |=> irq && ((r_reg.irq_st & $past(ev)) == $past(ev)))
    else $error("unmasked event lost or without interrupt");
  chk_timeout_flag: assert property (
    to_fire |=> r_reg.to_flag && !r_reg.to_en && !r_reg.bus_busy_flag)
    else $error("time-out did not reset the link");
  chk_wake_match: assert property (
    s_addr_done ##0 r_reg.addr_match_wake_en |=> wake_req)
    else $error("address match did not wake the core");

endmodule

`default_nettype wire

// ---- bench/i2c_master_model.sv ----
// behavioural i2c bus master: start, stop and nine-clock byte slots.
// assumes the bench resolves scl_line and sda_line with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic m_scl_oe,
  output logic m_sda_oe
);
  localparam int QTR_NS = 16;
  int stall_cnt = 0;

  initial begin
    m_scl_oe = 1'b0;
    m_sda_oe = 1'b0;
  end

  // release scl and wait while the slave stretches it
  task automatic scl_rise();
    int t;
    t = 0;
    m_scl_oe = 1'b0;
    while (scl_line !== 1'b1 && t < 20000) begin
      #1;
      t++;
    end
    if (t >= 20000) stall_cnt++;
  endtask

  // sda falls while scl is high
  task automatic start();
    m_sda_oe = 1'b0;
    #QTR_NS;
    scl_rise();
    #(2*QTR_NS);
    m_sda_oe = 1'b1;
    #(2*QTR_NS);
    m_scl_oe = 1'b1;
    #QTR_NS;
  endtask

  // sda rises while scl is high, ends a refused or finished transfer
  task automatic stop();
    m_sda_oe = 1'b1;
    #QTR_NS;
    scl_rise();
    #(2*QTR_NS);
    m_sda_oe = 1'b0;
    #(2*QTR_NS);
  endtask

  // nine clocks, msb first; a zero in out9 pulls sda low
  task automatic slot9(input logic [8:0] out9, output logic [8:0] in9);
    for (int k = 8; k >= 0; k--) begin
      m_sda_oe = ~out9[k];
      #QTR_NS;
      scl_rise();
      #QTR_NS;
      in9[k] = sda_line;
      #QTR_NS;
      m_scl_oe = 1'b1;
      #QTR_NS;
    end
    m_sda_oe = 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench: apb master, i2c master model, byte queue model.
// assumes the i2c slave package and design sources are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import i2c_slave_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, last_err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, wake_req;
  logic m_scl_oe, m_sda_oe;
  wire logic scl_line = !scl_oe && !m_scl_oe;
  wire logic sda_line = !sda_oe && !m_sda_oe;
  int err_total = 0;
  int n_compared = 0;
  int wake_cnt = 0;
  integer seed = 32'h95b3;
  logic [8:0] got;
  logic [7:0] byte_q[$];

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  i2c_slave_interface #(.TO_CYCLES(16)) i2c_slave_interface_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq), .wake_req(wake_req));

  i2c_master_model i2c_master_model_inst (.scl_line(scl_line),
    .sda_line(sda_line), .m_scl_oe(m_scl_oe), .m_sda_oe(m_sda_oe));

  always @(posedge pclk) if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                        input logic [31:0] exp, input logic [31:0] msk = 32'hff);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(what, q & msk, exp);
  endtask

  task automatic addr_phase(input logic [6:0] a, input logic rw,
                            input logic ack);
    i2c_master_model_inst.start();
    i2c_master_model_inst.slot9({a, rw, 1'b1}, got);
    chk("address bits", {24'h0, got[8:1]}, {24'h0, a, rw});
    chk("address ack", {31'h0, got[0]}, {31'h0, !ack});
    repeat (4) @(posedge pclk);
  endtask

  task automatic conclude();
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    conclude();
  end

  initial begin
    logic [6:0] own;
    logic [7:0] b;
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("module control", OFS_MODULE_CONTROL, 32'he0);
    rd_chk("status reset", OFS_STATUS_CONTROL, 32'h81);
    for (int i = 2; i < 8; i++) rd_chk("zero reset", 8'(i * 4), 32'h0);
    apb(1'b0, 8'h20, 32'h0, rd_v);
    chk("unmapped error", {31'h0, last_err}, 32'h1);
    chk("unmapped data", rd_v, 32'h0);
    wr(OFS_STATUS_CONTROL, 32'hff);
    rd_chk("status access", OFS_STATUS_CONTROL, 32'h9b);
    own = 7'($random(seed));
    wr(OFS_MODULE_CONTROL, {24'h0, MODE_I2C_SLAVE, 5'h02});
    wr(OFS_OWN_ADDRESS, {25'h0, own});
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_IRQ_ENABLE, 32'h1);
    wr(OFS_STATUS_CONTROL, 32'h02);
    // master writes: address, then bytes, the last one refused
    addr_phase(own, 1'b0, 1'b1);
    chk("hold scl", {31'h0, scl_oe}, 32'h1);
    chk("irq match", {31'h0, irq}, 32'h1);
    chk("wake pulse", wake_cnt, 1);
    rd_chk("rx match", OFS_STATUS_CONTROL, 32'h62, 32'h7e);
    rd_chk("irq status", OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, OFS_SERIAL_DATA, 32'h0, rd_v);
    repeat (4) @(posedge pclk);
    chk("scl free", {31'h0, scl_oe}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      if (i == 3) wr(OFS_STATUS_CONTROL, 32'h0a);
      byte_q.push_back(b);
      i2c_master_model_inst.slot9({b, 1'b1}, got);
      chk("data ack", {31'h0, got[0]}, {31'h0, i == 3});
      repeat (4) @(posedge pclk);
      rd_chk("byte done", OFS_IRQ_STATUS, 32'h2);
      wr(OFS_IRQ_STATUS, 32'h2);
      rd_chk("complete", OFS_STATUS_CONTROL, 32'h80, 32'h80);
      rd_chk("rx data", OFS_SERIAL_DATA, {24'h0, byte_q.pop_front()});
    end
    wr(OFS_STATUS_CONTROL, 32'h02);
    i2c_master_model_inst.stop();
    repeat (4) @(posedge pclk);
    rd_chk("bus free", OFS_STATUS_CONTROL, 32'h0, 32'h20);
    // another address: no ack, no flag, no wake
    addr_phase(own ^ 7'h01, 1'b0, 1'b0);
    rd_chk("no match", OFS_STATUS_CONTROL, 32'h20, 32'h60);
    rd_chk("no irq", OFS_IRQ_STATUS, 32'h0);
    chk("no wake", wake_cnt, 1);
    i2c_master_model_inst.stop();
    wr(OFS_STATUS_CONTROL, 32'h0);
    // master reads two bytes, interrupt masked at first
    wr(OFS_IRQ_MASK, 32'h0);
    addr_phase(own, 1'b1, 1'b1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd_chk("tx match", OFS_STATUS_CONTROL, 32'h64, 32'h7e);
    chk("wake off", wake_cnt, 1);
    wr(OFS_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    b = 8'($random(seed));
    wr(OFS_STATUS_CONTROL, 32'h10);
    wr(OFS_SERIAL_DATA, {24'h0, b});
    repeat (4) @(posedge pclk);
    chk("scl after write", {31'h0, scl_oe}, 32'h0);
    i2c_master_model_inst.slot9({8'hff, 1'b0}, got);
    chk("tx byte", {24'h0, got[8:1]}, {24'h0, b});
    repeat (4) @(posedge pclk);
    rd_chk("ack seen", OFS_STATUS_CONTROL, 32'h0, 32'h1);
    i2c_master_model_inst.slot9({8'hff, 1'b1}, got);
    chk("tx again", {24'h0, got[8:1]}, {24'h0, b});
    repeat (4) @(posedge pclk);
    rd_chk("nack seen", OFS_STATUS_CONTROL, 32'h1, 32'h1);
    chk("sda released", {31'h0, sda_oe}, 32'h0);
    i2c_master_model_inst.stop();
    wr(OFS_STATUS_CONTROL, 32'h0);
    // master stalls after the address: time-out after two units
    wr(OFS_IRQ_MASK, 32'h4);
    wr(OFS_TIMEOUT_CONTROL, 32'h81);
    addr_phase(own, 1'b0, 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("timeout delay", {31'h0, n >= 24 && n <= 44}, 32'h1);
    rd_chk("timeout reg", OFS_TIMEOUT_CONTROL, 32'h41);
    rd_chk("status back", OFS_STATUS_CONTROL, 32'h81);
    rd_chk("irq timeout", OFS_IRQ_STATUS, 32'h4, 32'h4);
    chk("scl on timeout", {31'h0, scl_oe}, 32'h0);
    i2c_master_model_inst.stop();
    chk("master stall", i2c_master_model_inst.stall_cnt, 0);
    // reset in mid-run: pins released, registers back to power-on
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pins in reset", {27'h0, irq, scl_oe, sda_oe, scl_out, sda_out},
        32'h0);
    presetn <= 1'b1;
    rd_chk("control after reset", OFS_MODULE_CONTROL, 32'he0);
    rd_chk("own after reset", OFS_OWN_ADDRESS, 32'h0);
    rd_chk("status after reset", OFS_STATUS_CONTROL, 32'h81);
    conclude();
  end
endmodule

`default_nettype wire
